// ==== hdl/pwmtc_pkg.sv ====
// Constants, field layout and helpers for the PWM timer count-clock block.
// Assumes a single 100 MHz aclk and an AXI4-Lite master with 32-bit data.
//
// Summary of operation
// - Prescaler divides source by 2^code, codes 0..14; code 15 stops counting.
// - Two-bit source field: 3 external, 2 high-speed, 0/1 internal oscillators.
// - Count clock reaches counter only while gate bit is 1; resets to 0.
// - Two-bit select picks which channel's counter feeds compare logic.
// - Compare buffer bit 1 defers compare loads to period end; else immediate.
// - One-shot select bit 1 gives one-shot counting, 0 repeat (reset).
// - Writing 1 to clear bit zeroes counter; bit is write-only, reads 0.
// - Counter advances while run bit is 1, holds at 0; run resets to 0.
// - Counter value register is read-only, 16 bits, resets to zero.
// - Control bits 15 to 6 read as zero and ignore writes.
`default_nettype none

package pwmtc_pkg;

    localparam int unsigned PWMTC_ADDR_W = 32;
    localparam int unsigned PWMTC_DATA_W = 32;
    localparam int unsigned PWMTC_COUNT_W = 16;
    localparam int unsigned PWMTC_PRESCALE_W = 14;

    // Register offsets are word indices; byte address is four times
    localparam logic [15:0] PWMTC_IDX_CLOCK_CONFIG = 16'h506b;
    localparam logic [15:0] PWMTC_IDX_COUNTER_CONTROL = 16'h5460;
    localparam logic [15:0] PWMTC_IDX_COUNTER_VALUE = 16'h5462;

    // count_clock_config fields
    localparam int unsigned PWMTC_RATIO_LSB = 4;
    localparam int unsigned PWMTC_RATIO_W = 4;
    localparam int unsigned PWMTC_SRC_LSB = 2;
    localparam int unsigned PWMTC_SRC_W = 2;
    localparam int unsigned PWMTC_GATE_BIT = 0;

    // counter_control fields
    localparam int unsigned PWMTC_SEL_LSB = 4;
    localparam int unsigned PWMTC_SEL_W = 2;
    localparam int unsigned PWMTC_BUF_BIT = 3;
    localparam int unsigned PWMTC_ONESHOT_BIT = 2;
    localparam int unsigned PWMTC_CLEAR_BIT = 1;
    localparam int unsigned PWMTC_RUN_BIT = 0;

    localparam logic [3:0] PWMTC_RATIO_RST = 4'h0;
    localparam logic [3:0] PWMTC_RATIO_INVALID = 4'hf;
    localparam logic [1:0] PWMTC_SEL_RST = 2'h0;
    localparam logic [15:0] PWMTC_COUNT_RST = 16'h0000;
    localparam logic [15:0] PWMTC_COUNT_MAX = 16'hffff;
    localparam logic [13:0] PWMTC_DIV_ZERO = 14'h0000;
    localparam logic [31:0] PWMTC_WORD_ZERO = 32'h0000_0000;

    localparam logic [1:0] PWMTC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PWMTC_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PWMTC_SRC_INTERNAL,
        PWMTC_SRC_SLOW,
        PWMTC_SRC_HIGH_SPEED,
        PWMTC_SRC_EXTERNAL
    } pwmtc_src_t;

    localparam pwmtc_src_t PWMTC_SRC_RST = PWMTC_SRC_INTERNAL;

    function automatic logic [31:0] pwmtc_byte_addr(input logic [15:0] idx);
        return {14'h0000, idx, 2'h0};
    endfunction : pwmtc_byte_addr

    function automatic logic [15:0] pwmtc_merge16(input logic [15:0] old,
                                                 input logic [31:0] data,
                                                 input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction : pwmtc_merge16

endpackage : pwmtc_pkg

`default_nettype wire

// ==== hdl/pwmtc_prescaler.sv ====
// Power-of-two prescaler on source ticks, one-cycle output tick.
// Assumes src_tick is a one-cycle enable synchronous to aclk.
`default_nettype none

module pwmtc_prescaler (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic enable,
    input wire logic src_tick,
    input wire logic [pwmtc_pkg::PWMTC_RATIO_W-1:0] ratio,
    output var logic count_tick
);
    import pwmtc_pkg::*;

    typedef struct packed {
        logic [PWMTC_PRESCALE_W-1:0] div;
        logic tick;
    } pwmtc_presc_state_t;

    pwmtc_presc_state_t state;
    pwmtc_presc_state_t next_state;
    logic [PWMTC_PRESCALE_W-1:0] mask;

    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        mask = (14'h0001 << ratio) - 14'h0001;
        if (!enable) begin
            next_state.div = PWMTC_DIV_ZERO;
        end else if (src_tick && ratio != PWMTC_RATIO_INVALID) begin
            if ((state.div & mask) == mask) begin
                next_state.tick = 1'b1;
                next_state.div = PWMTC_DIV_ZERO;
            end else begin
                next_state.div = state.div + 14'h0001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign count_tick = state.tick;

endmodule : pwmtc_prescaler

`default_nettype wire

// ==== hdl/pwmtc_top.sv ====
// Count-clock selection and counter control for one PWM timer channel.
// Assumes an AXI4-Lite master, one aclk, and synchronous oscillator ticks.
//
// Implementation choice: register access over AXI4-Lite.
`default_nettype none

module pwmtc_top (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [pwmtc_pkg::PWMTC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output var logic s_axi_awready,
    input wire logic [pwmtc_pkg::PWMTC_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output var logic s_axi_wready,
    output var logic [1:0] s_axi_bresp,
    output var logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pwmtc_pkg::PWMTC_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output var logic s_axi_arready,
    output var logic [pwmtc_pkg::PWMTC_DATA_W-1:0] s_axi_rdata,
    output var logic [1:0] s_axi_rresp,
    output var logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Count clock sources
    input wire logic internal_oscillator_tick,
    input wire logic slow_oscillator_tick,
    input wire logic high_speed_oscillator_tick,
    input wire logic external_count_clock,
    // Compare/capture side
    input wire logic period_match,
    input wire logic [pwmtc_pkg::PWMTC_COUNT_W-1:0] channel0_count,
    input wire logic [pwmtc_pkg::PWMTC_COUNT_W-1:0] channel1_count,
    input wire logic [pwmtc_pkg::PWMTC_COUNT_W-1:0] channel2_count,
    output var logic [pwmtc_pkg::PWMTC_COUNT_W-1:0] compare_count,
    output var logic compare_load,
    output var logic compare_buffer_on,
    output var logic [pwmtc_pkg::PWMTC_COUNT_W-1:0] counter_value
);
    import pwmtc_pkg::*;

    typedef struct packed {
        logic awready;
        logic aw_held;
        logic [PWMTC_ADDR_W-1:0] aw_addr;
        logic wready;
        logic w_held;
        logic [PWMTC_DATA_W-1:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [PWMTC_DATA_W-1:0] rdata;
        logic [PWMTC_RATIO_W-1:0] prescale_ratio;
        pwmtc_src_t count_clock_source;
        logic count_clock_gate;
        logic [PWMTC_SEL_W-1:0] compare_counter_select;
        logic compare_buffer_on;
        logic one_shot_select;
        logic counter_run;
        logic [PWMTC_COUNT_W-1:0] counter_value;
        logic [PWMTC_COUNT_W-1:0] compare_count;
        logic compare_load;
        logic ext_prev;
    } pwmtc_state_t;

    pwmtc_state_t state;
    pwmtc_state_t next_state;
    logic src_tick;
    logic count_tick;
    logic [PWMTC_COUNT_W-1:0] ctl_word;
    logic [PWMTC_COUNT_W-1:0] cfg_word;
    logic [PWMTC_COUNT_W-1:0] wr_word;
    logic period_end;
    logic do_write;
    logic clear_req;
    logic ctl_write;

    typedef enum logic [1:0] {
        PWMTC_REG_CONFIG,
        PWMTC_REG_CONTROL,
        PWMTC_REG_VALUE,
        PWMTC_REG_NONE
    } pwmtc_reg_t;

    // One decoder for both paths, so write and read maps cannot drift
    function automatic pwmtc_reg_t pwmtc_decode(
            input logic [PWMTC_ADDR_W-1:0] addr);
        pwmtc_reg_t hit;
        hit = PWMTC_REG_NONE;
        if (addr == pwmtc_byte_addr(PWMTC_IDX_CLOCK_CONFIG)) begin
            hit = PWMTC_REG_CONFIG;
        end
        if (addr == pwmtc_byte_addr(PWMTC_IDX_COUNTER_CONTROL)) begin
            hit = PWMTC_REG_CONTROL;
        end
        if (addr == pwmtc_byte_addr(PWMTC_IDX_COUNTER_VALUE)) begin
            hit = PWMTC_REG_VALUE;
        end
        return hit;
    endfunction : pwmtc_decode

    always_comb begin
        unique case (state.count_clock_source)
            PWMTC_SRC_INTERNAL: src_tick = internal_oscillator_tick;
            PWMTC_SRC_SLOW: src_tick = slow_oscillator_tick;
            PWMTC_SRC_HIGH_SPEED: src_tick = high_speed_oscillator_tick;
            PWMTC_SRC_EXTERNAL: begin
                src_tick = external_count_clock && !state.ext_prev;
            end
        endcase
    end

    pwmtc_prescaler u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(state.count_clock_gate),
        .src_tick(src_tick),
        .ratio(state.prescale_ratio),
        .count_tick(count_tick)
    );

    // Read views of the two control registers
    always_comb begin
        cfg_word = '0;
        cfg_word[PWMTC_RATIO_LSB +: PWMTC_RATIO_W] = state.prescale_ratio;
        cfg_word[PWMTC_SRC_LSB +: PWMTC_SRC_W] = state.count_clock_source;
        cfg_word[PWMTC_GATE_BIT] = state.count_clock_gate;
        ctl_word = '0;
        ctl_word[PWMTC_SEL_LSB +: PWMTC_SEL_W] = state.compare_counter_select;
        ctl_word[PWMTC_BUF_BIT] = state.compare_buffer_on;
        ctl_word[PWMTC_ONESHOT_BIT] = state.one_shot_select;
        ctl_word[PWMTC_CLEAR_BIT] = 1'b0;
        ctl_word[PWMTC_RUN_BIT] = state.counter_run;
    end

    always_comb begin
        next_state = state;
        next_state.ext_prev = external_count_clock;
        do_write = 1'b0;
        clear_req = 1'b0;
        ctl_write = 1'b0;
        period_end = 1'b0;
        wr_word = '0;

        // Write address and data are taken in either order
        if (s_axi_awvalid && state.awready) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state.wready) begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        if (state.aw_held && state.w_held && !state.bvalid) begin
            do_write = 1'b1;
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = PWMTC_RESP_OKAY;
        end

        if (do_write) begin
            unique case (pwmtc_decode(state.aw_addr))
                PWMTC_REG_CONFIG: begin
                    // Only the low byte lane exists here
                    wr_word = pwmtc_merge16(cfg_word, state.w_data,
                                            {3'h0, state.w_strb[0]});
                    next_state.prescale_ratio =
                        wr_word[PWMTC_RATIO_LSB +: PWMTC_RATIO_W];
                    next_state.count_clock_source =
                        pwmtc_src_t'(wr_word[PWMTC_SRC_LSB +: PWMTC_SRC_W]);
                    next_state.count_clock_gate = wr_word[PWMTC_GATE_BIT];
                end
                PWMTC_REG_CONTROL: begin
                    ctl_write = 1'b1;
                    // Only bits 5 to 2 and bit 0 are stored; bit 1 is the clear strobe
                    wr_word = pwmtc_merge16(ctl_word, state.w_data,
                                            state.w_strb);
                    next_state.compare_counter_select =
                        wr_word[PWMTC_SEL_LSB +: PWMTC_SEL_W];
                    next_state.compare_buffer_on = wr_word[PWMTC_BUF_BIT];
                    next_state.one_shot_select = wr_word[PWMTC_ONESHOT_BIT];
                    clear_req = wr_word[PWMTC_CLEAR_BIT];
                    next_state.counter_run = wr_word[PWMTC_RUN_BIT];
                end
                PWMTC_REG_VALUE: begin
                    wr_word = '0;
                end
                PWMTC_REG_NONE: begin
                    next_state.bresp = PWMTC_RESP_SLVERR;
                end
            endcase
        end

        // Read channel: one read at a time
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
        if (s_axi_arvalid && state.arready) begin
            next_state.rvalid = 1'b1;
            next_state.rresp = PWMTC_RESP_OKAY;
            next_state.rdata = PWMTC_WORD_ZERO;
            unique case (pwmtc_decode(s_axi_araddr))
                PWMTC_REG_CONFIG: begin
                    next_state.rdata[PWMTC_COUNT_W-1:0] = cfg_word;
                end
                PWMTC_REG_CONTROL: begin
                    next_state.rdata[PWMTC_COUNT_W-1:0] = ctl_word;
                end
                PWMTC_REG_VALUE: begin
                    next_state.rdata[PWMTC_COUNT_W-1:0] =
                        state.counter_value;
                end
                PWMTC_REG_NONE: begin
                    next_state.rresp = PWMTC_RESP_SLVERR;
                end
            endcase
        end

        if (count_tick && state.counter_run) begin
            // Wrap or match ends a period
            if (period_match || state.counter_value == PWMTC_COUNT_MAX) begin
                period_end = 1'b1;
                next_state.counter_value = PWMTC_COUNT_RST;
                // One-shot stops; a same-cycle software run write wins
                if (state.one_shot_select && !ctl_write) begin
                    next_state.counter_run = 1'b0;
                end
            end else begin
                next_state.counter_value =
                    state.counter_value + 16'h0001;
            end
        end
        if (clear_req) begin
            next_state.counter_value = PWMTC_COUNT_RST;
        end

        next_state.compare_load = !state.compare_buffer_on || period_end;

        unique case (state.compare_counter_select)
            2'h0: next_state.compare_count = channel0_count;
            2'h1: next_state.compare_count = channel1_count;
            2'h2: next_state.compare_count = channel2_count;
            2'h3: next_state.compare_count = state.counter_value;
        endcase

        // Ready flags registered so outputs come from flops
        next_state.awready = !next_state.aw_held && !next_state.bvalid;
        next_state.wready = !next_state.w_held && !next_state.bvalid;
        next_state.arready = !next_state.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
            state.prescale_ratio <= PWMTC_RATIO_RST;
            state.count_clock_source <= PWMTC_SRC_RST;
            state.compare_counter_select <= PWMTC_SEL_RST;
            state.counter_value <= PWMTC_COUNT_RST;
            // Buffer off at reset, so loads pass straight through
            state.compare_load <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign s_axi_awready = state.awready;
    assign s_axi_wready = state.wready;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_arready = state.arready;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rresp = state.rresp;
    assign s_axi_rdata = state.rdata;
    assign compare_count = state.compare_count;
    assign compare_load = state.compare_load;
    assign compare_buffer_on = state.compare_buffer_on;
    assign counter_value = state.counter_value;

endmodule : pwmtc_top

`default_nettype wire

// ==== testbench/pwmtc_chk.sv ====
// Port-level checks for the PWM timer count-clock block.
// Assumes binding to pwmtc_top; every signal is in the aclk domain.
`default_nettype none

module pwmtc_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [pwmtc_pkg::PWMTC_DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic internal_oscillator_tick,
    input wire logic slow_oscillator_tick,
    input wire logic high_speed_oscillator_tick,
    input wire logic external_count_clock,
    input wire logic compare_load,
    input wire logic compare_buffer_on,
    input wire logic [pwmtc_pkg::PWMTC_COUNT_W-1:0] counter_value
);
    import pwmtc_pkg::*;
    // External level counts as activity: loose but never a false alarm
    logic [3:0] hist;
    always_ff @(posedge aclk) begin
        hist <= {hist[2:0], internal_oscillator_tick | slow_oscillator_tick
            | high_speed_oscillator_tick | external_count_clock};
    end
    default clocking cb_clk @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_count_step: assert property ($changed(counter_value) |->
        counter_value == $past(counter_value) + 16'h1
        || counter_value == PWMTC_COUNT_RST) else $error("count jumped");
    a_tick_cause: assert property ($changed(counter_value)
        && counter_value != PWMTC_COUNT_RST |-> hist != 4'h0)
        else $error("count moved without a source tick");
    a_rdata_upper: assert property (s_axi_rvalid |->
        s_axi_rdata[31:16] == 16'h0) else $error("upper read bits set");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during answer");
    a_aw_refused: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    a_load_direct: assert property (!compare_buffer_on
        ##1 !compare_buffer_on |-> compare_load)
        else $error("unbuffered compare load low");
    a_load_pulse: assert property (compare_buffer_on
        && $past(compare_buffer_on) && compare_load
        |=> !compare_load || !compare_buffer_on)
        else $error("buffered compare load too long");
    a_reset_zero: assert property (disable iff (1'b0)
        $rose(aresetn) |-> counter_value == PWMTC_COUNT_RST)
        else $error("counter not zero after reset");
endmodule : pwmtc_chk

bind pwmtc_top pwmtc_chk i_chk (.aclk, .aresetn, .s_axi_awready,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .internal_oscillator_tick,
    .slow_oscillator_tick, .high_speed_oscillator_tick,
    .external_count_clock, .compare_load, .compare_buffer_on,
    .counter_value);

`default_nettype wire

// ==== testbench/tb_pwm_timer_counter_clock_ctrl.sv ====
// Self-checking bench for the PWM timer count-clock block.
// Assumes the AXI4-Lite timing and tick pipeline of pwmtc_top.
`default_nettype none

module tb_pwm_timer_counter_clock_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import pwmtc_pkg::*;
    localparam logic [31:0] AD_CFG = 32'h000141ac;
    localparam logic [31:0] AD_CTL = 32'h00015180;
    localparam logic [31:0] AD_VAL = 32'h00015188;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, pm = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
    logic [3:0] wstrb = 0, tk = 0;
    logic [15:0] c0 = 16'h1111, c1 = 16'h2222, c2 = 16'h3333;
    wire logic awready, wready, bvalid, arready, rvalid, cl, cb;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [15:0] cc, cv;
    int errors = 0, total_checks = 0, cyc = 0;

    pwmtc_top i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .internal_oscillator_tick(tk[0]),
        .slow_oscillator_tick(tk[1]), .high_speed_oscillator_tick(tk[2]),
        .external_count_clock(tk[3]), .period_match(pm),
        .channel0_count(c0), .channel1_count(c1), .channel2_count(c2),
        .compare_count(cc), .compare_load(cl), .compare_buffer_on(cb),
        .counter_value(cv));

    always #5 aclk = ~aclk;

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge aclk) begin
        cyc++;
        if (cyc > 20000) begin
            errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk

    // Ready is a flop, so its negedge value is the one the next edge sees
    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      input logic [1:0] er = PWMTC_RESP_OKAY);
        logic ta, tw, ha, hw;
        ta = 0;
        tw = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'h3;
        awvalid <= 1;
        wvalid <= 1;
        while (!(ta && tw)) begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            @(posedge aclk);
            if (ha) awvalid <= 0;
            if (hw) wvalid <= 0;
            ta = ta || ha;
            tw = tw || hw;
        end
        bready <= 1;
        do @(negedge aclk); while (bvalid !== 1'b1);
        chk("bresp", 32'(er), 32'(bresp));
        @(posedge aclk);
        bready <= 0;
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        araddr <= a;
        arvalid <= 1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 0;
        rready <= 1;
        do @(negedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge aclk);
        rready <= 0;
    endtask : rd

    task automatic rc(input logic [31:0] a, input logic [31:0] e,
                      input string n);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(n, e, d);
        chk("rresp", 32'(PWMTC_RESP_OKAY), 32'(r));
    endtask : rc

    // Gate off first so the divider restarts from zero
    task automatic go(input logic [31:0] c, input logic [31:0] t);
        wr(AD_CFG, 32'h0);
        wr(AD_CFG, c);
        wr(AD_CTL, t);
    endtask : go

    task automatic pulse(input int s, input int n);
        repeat (n) begin
            tk <= 4'(1 << s);
            @(posedge aclk);
            tk <= 4'h0;
            repeat (2) @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
    endtask : pulse

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        rc(AD_CFG, 32'h0, "config reset");
        rc(AD_CTL, 32'h0, "control reset");
        rc(AD_VAL, 32'h0, "value reset");
        rd(32'h00015190, d, r);
        chk("unmapped rresp", 32'(PWMTC_RESP_SLVERR), 32'(r));
        chk("unmapped rdata", 32'h0, d);
        wr(32'h00015190, 32'h1, PWMTC_RESP_SLVERR);
        chk("compare_load", 32'h1, 32'(cl));
        $display("test reset done");
    endtask : t_reset

    task automatic t_regs();
        wr(AD_CFG, 32'hffff_ffff);
        rc(AD_CFG, 32'hfd, "config bits");
        wr(AD_CTL, 32'hffff_ffff);
        rc(AD_CTL, 32'h3d, "control bits");
        chk("buffer flag", 32'h1, 32'(cb));
        chk("compare_load", 32'h0, 32'(cl));
        chk("own count", 32'(PWMTC_COUNT_RST), 32'(cc));
        go(32'h0, 32'h0);
        $display("test registers done");
    endtask : t_regs

    task automatic t_count();
        for (int k = 0; k < 4; k++) begin
            go(32'((k << 4) | 1), 32'h3);
            pulse(0, 3 << k);
            rc(AD_VAL, 32'h3, "divided count");
            chk("counter_value", 32'h3, 32'(cv));
        end
        for (int s = 0; s < 4; s++) begin
            go(32'((s << 2) | 1), 32'h3);
            for (int j = 0; j < 4; j++) pulse(j, 1);
            rc(AD_VAL, 32'h1, "source count");
        end
        $display("test counting done");
    endtask : t_count

    task automatic t_hold();
        logic [31:0] cf [3] = '{32'hf1, 32'h00, 32'h01};
        logic [31:0] ct [3] = '{32'h03, 32'h03, 32'h02};
        for (int i = 0; i < 3; i++) begin
            go(cf[i], ct[i]);
            pulse(0, 4);
            rc(AD_VAL, 32'h0, "blocked count");
        end
        go(32'h01, 32'h03);
        pulse(0, 2);
        wr(AD_CTL, 32'h0);
        pulse(0, 2);
        rc(AD_VAL, 32'h2, "stopped count");
        wr(AD_VAL, 32'h1234);
        rc(AD_VAL, 32'h2, "value after write");
        rc(AD_CTL, 32'h0, "clear reads zero");
        wr(AD_CTL, 32'h2);
        rc(AD_VAL, 32'h0, "cleared count");
        $display("test hold done");
    endtask : t_hold

    task automatic t_period();
        go(32'h01, 32'h07);
        pm <= 1;
        pulse(0, 1);
        pm <= 0;
        rc(AD_CTL, 32'h04, "one-shot run");
        pulse(0, 2);
        rc(AD_VAL, 32'h0, "one-shot count");
        go(32'h01, 32'h0b);
        pulse(0, 2);
        pm <= 1;
        pulse(0, 1);
        pm <= 0;
        rc(AD_CTL, 32'h09, "repeat run");
        pulse(0, 1);
        rc(AD_VAL, 32'h1, "repeat count");
        $display("test period done");
    endtask : t_period

    task automatic t_select();
        for (int s = 0; s < 3; s++) begin
            wr(AD_CTL, 32'(s << 4));
            repeat (3) @(posedge aclk);
            chk("compare_count", 32'(16'h1111 * (s + 1)), 32'(cc));
        end
        $display("test select done");
    endtask : t_select

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset();
        t_regs();
        t_count();
        t_hold();
        t_period();
        t_select();
        finish_test();
    end
endmodule : tb_pwm_timer_counter_clock_ctrl

`default_nettype wire
